/* logic/usb_device_endpoint_control.v */
// Control of endpoint slot d handshakes and toggle, and slot e size and configuration registers.
// Assumes a transaction engine that reports token start, end, error-free status and packet kind
// as one-cycle pulses, and software on a byte-addressed Avalon-MM bus.
// Slot d transfer type, toggle mode and packet size live in neighbouring logic.
//
// Overview of operation
// - Error-free transaction end sets forced NAK when enabled.
// - Short enable sends short packets or zero length.
// - Short enable clears after short IN completes.
// - Short OUT packet sets forced NAK unless disabled.
// - Auto NAK on complete wins over disable.
// - Toggle state bit reads current data toggle.
// - Force-one sets toggle, force-zero clears, zero wins.
// - Forced NAK answers every transaction with NAK.
// - NAK written mid-transaction waits for its end.
// - Forced STALL answers STALL, overriding NAK.
// - STALL set mid-transaction applies from next one.
// - Eleven-bit max packet size, split high and low.
// - Direction bit: zero OUT, one IN.
// - IN interrupt mode flips toggle every transaction.
// - OUT interrupt mode disables PING flow control.
// - Isochronous bit selects isochronous; bit four reserved.
`timescale 1ns/10ps
`include "usb_ep_regs.vh"

module usb_device_endpoint_control #(
	parameter SIZE_W = 11
) (
	input wire sys_clk,
	input wire rst_n,
	input wire [`EP_ADDR_W-1:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [3:0] avs_byteenable,
	input wire [31:0] avs_writedata,
	output wire avs_waitrequest,
	output wire [31:0] avs_readdata,
	input wire d_txn_start,
	input wire d_txn_end,
	input wire d_txn_ok,
	input wire d_txn_in,
	input wire d_txn_short,
	input wire d_txn_toggle,
	input wire d_fifo_empty,
	input wire d_fifo_below_max,
	output wire d_resp_stall,
	output wire d_resp_nak,
	output wire d_toggle,
	output wire d_in_send_ready,
	output wire d_in_send_zero_length,
	output wire d_short_packet_enable,
	output wire d_busy,
	output wire [SIZE_W-1:0] slot_e_max_packet_bytes,
	output wire e_direction_select,
	output wire e_interrupt_mode,
	output wire e_isochronous,
	output wire [3:0] e_ep_index,
	output wire e_always_toggle,
	output wire e_ping_enable
);

	wire [`EP_IDX_W-1:0] reg_index;
	wire reg_write;
	wire [7:0] reg_wdata;
	reg [7:0] reg_rdata;

	// Reset images of the control and configuration registers, so each field's reset value has one source.
	wire [7:0] ctrl_reset_value;
	wire [7:0] cfg_reset_value;

	assign ctrl_reset_value = `EP_CTRL_RESET;
	assign cfg_reset_value = `EP_CFG_RESET;

	// Every access takes exactly one wait state; the slave registers the read data.
	ep_bus_slave u_bus (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_byteenable(avs_byteenable),
		.avs_writedata(avs_writedata),
		.avs_waitrequest(avs_waitrequest),
		.avs_readdata(avs_readdata),
		.reg_index(reg_index),
		.reg_write(reg_write),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata)
	);

	// Write strobes per register. They come from the acknowledged cycle only,
	// so the stalled first cycle of a request can never write twice.
	reg wr_ctrl;
	reg wr_size_h;
	reg wr_size_l;
	reg wr_cfg;

	always @* begin
		wr_ctrl = 1'b0;
		wr_size_h = 1'b0;
		wr_size_l = 1'b0;
		wr_cfg = 1'b0;
		if (reg_index == `EP_IDX_D_CTRL) begin
			wr_ctrl = reg_write;
		end else if (reg_index == `EP_IDX_E_SIZE_H) begin
			wr_size_h = reg_write;
		end else if (reg_index == `EP_IDX_E_SIZE_L) begin
			wr_size_l = reg_write;
		end else if (reg_index == `EP_IDX_E_CFG) begin
			wr_cfg = reg_write;
		end
	end

	// Slot d control state.
	reg auto_nak_on_complete_reg;
	reg auto_nak_on_complete_next;
	reg short_packet_enable_reg;
	reg short_packet_enable_next;
	reg short_receive_nak_disable_reg;
	reg short_receive_nak_disable_next;
	reg toggle_state_reg;
	reg toggle_state_next;
	reg forced_nak_reg;
	reg forced_nak_next;
	reg nak_pending_reg;
	reg nak_pending_next;
	reg forced_stall_reg;
	reg forced_stall_next;
	reg stall_active_reg;
	reg stall_active_next;
	reg busy_reg;
	reg busy_next;
	// The NAK answer has its own flop so the host sees a clean level, already masked by STALL.
	reg resp_nak_reg;
	reg resp_nak_next;

	wire end_ok;
	wire short_receive_auto_nak;
	wire auto_nak_event;

	// Engine qualifiers are only meaningful in the cycle of the end pulse.
	assign end_ok = d_txn_end & d_txn_ok;
	// The disable bit only matters while the complete-based auto NAK is off.
	assign short_receive_auto_nak = ~short_receive_nak_disable_reg & ~d_txn_in & d_txn_short;
	assign auto_nak_event = end_ok & (auto_nak_on_complete_reg | short_receive_auto_nak);

	always @* begin
		auto_nak_on_complete_next = auto_nak_on_complete_reg;
		short_packet_enable_next = short_packet_enable_reg;
		short_receive_nak_disable_next = short_receive_nak_disable_reg;
		toggle_state_next = toggle_state_reg;
		forced_nak_next = forced_nak_reg;
		nak_pending_next = nak_pending_reg;
		forced_stall_next = forced_stall_reg;
		stall_active_next = stall_active_reg;
		busy_next = busy_reg;

		// An end pulse closes the transaction even without a seen start, so a lost start cannot wedge busy.
		if (d_txn_start) begin
			busy_next = 1'b1;
		end else if (d_txn_end) begin
			busy_next = 1'b0;
		end

		// Engine-driven updates come first so that a register write in the same cycle decides.
		if (end_ok && d_txn_in && d_txn_short) begin
			short_packet_enable_next = 1'b0;
		end
		if (d_txn_toggle) begin
			toggle_state_next = ~toggle_state_reg;
		end
		if (d_txn_end && nak_pending_reg) begin
			forced_nak_next = 1'b1;
			nak_pending_next = 1'b0;
		end

		if (wr_ctrl) begin
			auto_nak_on_complete_next = reg_wdata[`CTRL_AUTO_NAK];
			short_receive_nak_disable_next = reg_wdata[`CTRL_SHORT_NAK_DIS];
			forced_stall_next = reg_wdata[`CTRL_FORCED_STALL];
			if (reg_wdata[`CTRL_SHORT_EN]) begin
				short_packet_enable_next = 1'b1;
			end else begin
				short_packet_enable_next = 1'b0;
			end
			// Toggle controls act only in the cycle of the write and are never stored.
			if (reg_wdata[`CTRL_TOGGLE_ZERO]) begin
				toggle_state_next = 1'b0;
			end else if (reg_wdata[`CTRL_TOGGLE_ONE]) begin
				toggle_state_next = 1'b1;
			end
			// A set during a transaction is parked so the host gets one consistent answer per token.
			if (!reg_wdata[`CTRL_FORCED_NAK]) begin
				forced_nak_next = 1'b0;
				nak_pending_next = 1'b0;
			end else if (busy_reg && !d_txn_end) begin
				nak_pending_next = 1'b1;
			end else begin
				forced_nak_next = 1'b1;
			end
		end

		// A hardware set is never lost to a software clear in the same cycle.
		if (auto_nak_event) begin
			forced_nak_next = 1'b1;
		end

		// The stall seen by the host is sampled only between transactions.
		// A STALL cleared mid-transaction likewise keeps answering STALL until that transaction ends.
		if (!busy_reg || d_txn_end) begin
			stall_active_next = forced_stall_next;
		end

		// STALL outranks NAK, so the NAK answer is dropped whenever STALL will be shown.
		resp_nak_next = forced_nak_next & ~stall_active_next;
	end

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			auto_nak_on_complete_reg <= ctrl_reset_value[`CTRL_AUTO_NAK];
			short_packet_enable_reg <= ctrl_reset_value[`CTRL_SHORT_EN];
			short_receive_nak_disable_reg <= ctrl_reset_value[`CTRL_SHORT_NAK_DIS];
			toggle_state_reg <= ctrl_reset_value[`CTRL_TOGGLE_STATE];
			forced_nak_reg <= ctrl_reset_value[`CTRL_FORCED_NAK];
			nak_pending_reg <= 1'b0;
			forced_stall_reg <= ctrl_reset_value[`CTRL_FORCED_STALL];
			stall_active_reg <= ctrl_reset_value[`CTRL_FORCED_STALL];
			resp_nak_reg <= ctrl_reset_value[`CTRL_FORCED_NAK] & ~ctrl_reset_value[`CTRL_FORCED_STALL];
			busy_reg <= 1'b0;
		end else begin
			auto_nak_on_complete_reg <= auto_nak_on_complete_next;
			short_packet_enable_reg <= short_packet_enable_next;
			short_receive_nak_disable_reg <= short_receive_nak_disable_next;
			toggle_state_reg <= toggle_state_next;
			forced_nak_reg <= forced_nak_next;
			nak_pending_reg <= nak_pending_next;
			forced_stall_reg <= forced_stall_next;
			stall_active_reg <= stall_active_next;
			resp_nak_reg <= resp_nak_next;
			busy_reg <= busy_next;
		end
	end

	assign d_resp_stall = stall_active_reg;
	assign d_resp_nak = resp_nak_reg;
	assign d_toggle = toggle_state_reg;
	assign d_short_packet_enable = short_packet_enable_reg;
	assign d_busy = busy_reg;
	// A full packet may always go; less than a full one only under short enable.
	// Software must not add FIFO data while short enable is set; this block cannot see it.
	assign d_in_send_ready = short_packet_enable_reg | (~d_fifo_empty & ~d_fifo_below_max);
	assign d_in_send_zero_length = short_packet_enable_reg & d_fifo_empty;

	// Slot e maximum packet size and configuration. Size limits per transfer type are
	// software's duty and are not checked here.
	reg [SIZE_W-1:0] max_packet_bytes_reg;
	reg [SIZE_W-1:0] max_packet_bytes_next;
	reg [7:0] config_reg;
	reg [7:0] config_next;
	reg always_toggle_reg;
	reg always_toggle_next;
	reg ping_enable_reg;
	reg ping_enable_next;

	// The two size halves are written separately; a mixed value stands between the two writes.
	always @* begin
		max_packet_bytes_next = max_packet_bytes_reg;
		if (wr_size_h) begin
			max_packet_bytes_next[`SIZE_HIGH_MSB:`SIZE_HIGH_LSB] = reg_wdata[`SIZE_HIGH_W-1:0];
		end
		if (wr_size_l) begin
			max_packet_bytes_next[`SIZE_LOW_MSB:0] = reg_wdata[`SIZE_LOW_MSB:0];
		end
	end

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			max_packet_bytes_reg <= `EP_SIZE_RESET;
		end else begin
			max_packet_bytes_reg <= max_packet_bytes_next;
		end
	end

	always @* begin
		config_next = config_reg;
		if (wr_cfg) begin
			// The reserved bit is stored as zero whatever is written, so it always reads back as zero.
			config_next = {reg_wdata[`CFG_DIR:`CFG_ISO], 1'b0, reg_wdata[`CFG_INDEX_MSB:`CFG_INDEX_LSB]};
		end
		// The decoded modes come from flops so downstream logic never sees a decode glitch.
		always_toggle_next = config_next[`CFG_DIR] & config_next[`CFG_INT_MODE];
		ping_enable_next = ~config_next[`CFG_DIR] & ~config_next[`CFG_INT_MODE];
	end

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			config_reg <= cfg_reset_value;
			always_toggle_reg <= cfg_reset_value[`CFG_DIR] & cfg_reset_value[`CFG_INT_MODE];
			ping_enable_reg <= ~cfg_reset_value[`CFG_DIR] & ~cfg_reset_value[`CFG_INT_MODE];
		end else begin
			config_reg <= config_next;
			always_toggle_reg <= always_toggle_next;
			ping_enable_reg <= ping_enable_next;
		end
	end

	assign slot_e_max_packet_bytes = max_packet_bytes_reg;
	assign e_direction_select = config_reg[`CFG_DIR];
	assign e_interrupt_mode = config_reg[`CFG_INT_MODE];
	assign e_isochronous = config_reg[`CFG_ISO];
	assign e_ep_index = config_reg[`CFG_INDEX_MSB:`CFG_INDEX_LSB];
	assign e_always_toggle = always_toggle_reg;
	assign e_ping_enable = ping_enable_reg;

	// Reading has no side effects, so the early capture in the bus slave is harmless.
	// Read-back; write-only toggle controls and reserved bits read as zero.
	always @* begin
		reg_rdata = 8'h00;
		if (reg_index == `EP_IDX_D_CTRL) begin
			reg_rdata[`CTRL_AUTO_NAK] = auto_nak_on_complete_reg;
			reg_rdata[`CTRL_SHORT_EN] = short_packet_enable_reg;
			reg_rdata[`CTRL_SHORT_NAK_DIS] = short_receive_nak_disable_reg;
			reg_rdata[`CTRL_TOGGLE_STATE] = toggle_state_reg;
			reg_rdata[`CTRL_FORCED_NAK] = forced_nak_reg;
			reg_rdata[`CTRL_FORCED_STALL] = forced_stall_reg;
		end else if (reg_index == `EP_IDX_E_SIZE_H) begin
			reg_rdata[`SIZE_HIGH_W-1:0] = max_packet_bytes_reg[`SIZE_HIGH_MSB:`SIZE_HIGH_LSB];
		end else if (reg_index == `EP_IDX_E_SIZE_L) begin
			reg_rdata = max_packet_bytes_reg[`SIZE_LOW_MSB:0];
		end else if (reg_index == `EP_IDX_E_CFG) begin
			reg_rdata = config_reg;
		end
	end

endmodule // usb_device_endpoint_control

/* shared/usb_ep_regs.vh */
// Register indexes, field positions and reset values of the endpoint control block.
// Assumes a byte-addressed 32-bit Avalon-MM bus; each register takes one word at four times its index.
`ifndef USB_EP_REGS_VH
`define USB_EP_REGS_VH

`define EP_ADDR_W 12
`define EP_IDX_W 10
`define EP_IDX_D_CTRL 10'h114
`define EP_IDX_E_SIZE_H 10'h118
`define EP_IDX_E_SIZE_L 10'h119
`define EP_IDX_E_CFG 10'h11A

`define EP_CTRL_RESET 8'h00
`define EP_SIZE_RESET 11'h000
`define EP_CFG_RESET 8'h00

`define CTRL_AUTO_NAK 7
`define CTRL_SHORT_EN 6
`define CTRL_SHORT_NAK_DIS 5
`define CTRL_TOGGLE_STATE 4
`define CTRL_TOGGLE_ONE 3
`define CTRL_TOGGLE_ZERO 2
`define CTRL_FORCED_NAK 1
`define CTRL_FORCED_STALL 0

`define SIZE_HIGH_MSB 10
`define SIZE_HIGH_LSB 8
`define SIZE_HIGH_W 3
`define SIZE_LOW_MSB 7

`define CFG_DIR 7
`define CFG_INT_MODE 6
`define CFG_ISO 5
`define CFG_INDEX_MSB 3
`define CFG_INDEX_LSB 0

`endif

/* logic/ep_bus_slave.v */
// Avalon-MM slave front end: one wait state on every access, read data registered.
// Assumes the master holds its request until it samples waitrequest low.
`timescale 1ns/10ps
`include "usb_ep_regs.vh"

module ep_bus_slave (
	input wire sys_clk,
	input wire rst_n,
	input wire [`EP_ADDR_W-1:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [3:0] avs_byteenable,
	input wire [31:0] avs_writedata,
	output wire avs_waitrequest,
	output reg [31:0] avs_readdata,
	output wire [`EP_IDX_W-1:0] reg_index,
	output wire reg_write,
	output wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata
);

	reg ack_reg;
	wire request;

	assign request = avs_read | avs_write;
	assign reg_index = avs_address[`EP_ADDR_W-1:2];
	// The first cycle of a request is always stalled, so the decode has a full cycle to settle.
	assign avs_waitrequest = request & ~ack_reg;
	// Only byte lane 0 holds register bits; a write without it touches nothing.
	assign reg_write = avs_write & ack_reg & avs_byteenable[0];
	assign reg_wdata = avs_writedata[7:0];

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= request & ~ack_reg;
		end
	end

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			avs_readdata <= 32'h00000000;
		end else if (avs_read && !ack_reg) begin
			avs_readdata <= {24'h000000, reg_rdata};
		end
	end

endmodule // ep_bus_slave

/* sim/usb_ep_ctrl_properties.sv */
// Concurrent checks on the ports of the endpoint control block.
// Assumes one clock with a synchronous active-low reset; bound to every instance of the block.
`timescale 1ns/10ps
`include "usb_ep_regs.vh"
module usb_ep_ctrl_properties (
	input wire sys_clk,
	input wire rst_n,
	input wire [`EP_ADDR_W-1:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [3:0] avs_byteenable,
	input wire [31:0] avs_writedata,
	input wire avs_waitrequest,
	input wire d_txn_end,
	input wire d_txn_ok,
	input wire d_txn_in,
	input wire d_txn_short,
	input wire d_busy,
	input wire d_resp_stall,
	input wire d_resp_nak,
	input wire d_toggle,
	input wire d_short_packet_enable
);
	// The control register is not visible here, so the auto-NAK enable and the short OUT NAK disable are shadowed from bus writes.
	reg auto_reg;
	reg dis_reg;
	wire wr_ctrl = avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address[11:2] == `EP_IDX_D_CTRL;
	wire ok_end = d_txn_end && d_txn_ok;
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			auto_reg <= 1'b0;
			dis_reg <= 1'b0;
		end else if (wr_ctrl) begin
			auto_reg <= avs_writedata[7];
			dis_reg <= avs_writedata[5];
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_short_in_done;
		ok_end && d_txn_in && d_txn_short && !wr_ctrl;
	endsequence
	sequence s_ctrl_in_busy;
		wr_ctrl && d_busy && !d_txn_end;
	endsequence
	a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("waitrequest low in first request cycle");
	a_wait_single: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("more than one wait state");
	a_auto_nak: assert property (ok_end && auto_reg |=> d_resp_nak || d_resp_stall)
		else $error("no forced NAK after completed transaction");
	a_short_out_nak: assert property (ok_end && !d_txn_in && d_txn_short && !dis_reg |=> d_resp_nak || d_resp_stall)
		else $error("no forced NAK after short OUT packet");
	a_short_clear: assert property (s_short_in_done |=> !d_short_packet_enable)
		else $error("short enable kept after short IN");
	a_toggle_force: assert property (wr_ctrl && |avs_writedata[3:2] |=> d_toggle == !$past(avs_writedata[2]))
		else $error("toggle force write not applied");
	a_nak_idle: assert property (wr_ctrl && avs_writedata[1] && !avs_writedata[0] && !d_busy && !d_resp_stall |=> d_resp_nak)
		else $error("forced NAK not set at once while idle");
	a_nak_deferred: assert property (s_ctrl_in_busy and avs_writedata[1] && !d_resp_nak |=> !d_resp_nak)
		else $error("forced NAK set during a transaction");
	a_stall_deferred: assert property (s_ctrl_in_busy and avs_writedata[0] && !d_resp_stall |=> !d_resp_stall)
		else $error("STALL applied to current transaction");
	a_stall_over_nak: assert property (d_resp_stall |-> !d_resp_nak)
		else $error("NAK and STALL together");
endmodule // usb_ep_ctrl_properties

bind usb_device_endpoint_control usb_ep_ctrl_properties u_props (
	.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
	.d_txn_end(d_txn_end), .d_txn_ok(d_txn_ok), .d_txn_in(d_txn_in), .d_txn_short(d_txn_short), .d_busy(d_busy),
	.d_resp_stall(d_resp_stall), .d_resp_nak(d_resp_nak), .d_toggle(d_toggle),
	.d_short_packet_enable(d_short_packet_enable)
);

/* sim/usb_host_model.sv */
// Behavioural USB host issuing one token at a time to endpoint slot d.
// Assumes the bench calls run from a single process clocked by sys_clk.
`timescale 1ns/10ps
module usb_host_model (
	input wire sys_clk,
	output reg d_txn_start,
	output reg d_txn_end,
	output reg d_txn_ok,
	output reg d_txn_in,
	output reg d_txn_short,
	output reg d_txn_toggle
);
	initial begin
		{d_txn_start, d_txn_end, d_txn_ok, d_txn_in, d_txn_short, d_txn_toggle} = 6'h00;
	end
	// Qualifiers mean nothing away from the end pulse, so they show the inverse there to catch misuse.
	task run(input [3:0] gap, input ok, input in, input sh);
		begin
			@(posedge sys_clk);
			d_txn_start <= 1'b1;
			@(posedge sys_clk);
			d_txn_start <= 1'b0;
			repeat (gap) @(posedge sys_clk);
			d_txn_end <= 1'b1;
			{d_txn_ok, d_txn_in, d_txn_short, d_txn_toggle} <= {ok, in, sh, ok};
			@(posedge sys_clk);
			{d_txn_end, d_txn_toggle} <= 2'b00;
			{d_txn_ok, d_txn_in, d_txn_short} <= ~{ok, in, sh};
		end
	endtask
endmodule // usb_host_model

/* sim/tb_usb_device_endpoint_control.sv */
// Self-checking bench for the endpoint control block: Avalon-MM tasks plus a host model.
// Assumes every bus access is answered by the design's own waitrequest.
`timescale 1ns/10ps
`include "usb_ep_regs.vh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fail_count++; \
	$display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb_usb_device_endpoint_control;
	reg sys_clk = 1'b0;
	reg rst_n = 1'b0;
	reg [`EP_ADDR_W-1:0] avs_address = 12'h000;
	reg avs_read = 1'b0;
	reg avs_write = 1'b0;
	reg [3:0] avs_byteenable = 4'h1;
	reg [31:0] avs_writedata = 32'h00000000;
	reg d_fifo_empty = 1'b1;
	reg d_fifo_below_max = 1'b1;
	wire avs_waitrequest, d_txn_start, d_txn_end, d_txn_ok, d_txn_in, d_txn_short, d_txn_toggle;
	wire d_resp_stall, d_resp_nak, d_toggle, d_in_send_ready, d_in_send_zero_length, d_short_packet_enable, d_busy;
	wire e_direction_select, e_interrupt_mode, e_isochronous, e_always_toggle, e_ping_enable;
	wire [31:0] avs_readdata;
	wire [10:0] slot_e_max_packet_bytes;
	wire [3:0] e_ep_index;
	integer fail_count = 0;
	integer cmp_count = 0;
	integer cyc = 0;
	integer i;
	reg [31:0] rd;
	reg [7:0] c;
	reg ok_b, in_b, sh_b, ek, es;
	reg exp_tog = 1'b0;
	reg [49:0] ridx = {10'h114, 10'h118, 10'h119, 10'h11A, 10'h117};
	reg [31:0] cfgs = 32'hB543C10F;
	reg [87:0] tcs = {11'h402, 11'h406, 11'h505, 11'h005, 11'h105, 11'h004, 11'h206, 11'h207};
	usb_device_endpoint_control uut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
		.avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata), .d_txn_start(d_txn_start),
		.d_txn_end(d_txn_end), .d_txn_ok(d_txn_ok), .d_txn_in(d_txn_in), .d_txn_short(d_txn_short),
		.d_txn_toggle(d_txn_toggle), .d_fifo_empty(d_fifo_empty), .d_fifo_below_max(d_fifo_below_max),
		.d_resp_stall(d_resp_stall), .d_resp_nak(d_resp_nak), .d_toggle(d_toggle), .d_in_send_ready(d_in_send_ready),
		.d_in_send_zero_length(d_in_send_zero_length), .d_short_packet_enable(d_short_packet_enable), .d_busy(d_busy),
		.slot_e_max_packet_bytes(slot_e_max_packet_bytes), .e_direction_select(e_direction_select),
		.e_interrupt_mode(e_interrupt_mode), .e_isochronous(e_isochronous), .e_ep_index(e_ep_index),
		.e_always_toggle(e_always_toggle), .e_ping_enable(e_ping_enable));
	usb_host_model host (.sys_clk(sys_clk), .d_txn_start(d_txn_start), .d_txn_end(d_txn_end), .d_txn_ok(d_txn_ok),
		.d_txn_in(d_txn_in), .d_txn_short(d_txn_short), .d_txn_toggle(d_txn_toggle));
	initial begin
		forever #10 sys_clk = ~sys_clk;
	end
	task wrap_up;
		begin
			if (fail_count == 0 && cmp_count > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	// The whole run needs well under a thousand cycles, so a hang is cut at four thousand.
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			fail_count++;
			wrap_up;
		end
	end
	task bus(input w, input [9:0] idx, input [7:0] wd);
		begin
			@(posedge sys_clk);
			avs_address <= {idx, 2'b00};
			{avs_write, avs_read} <= {w, !w};
			avs_writedata <= {24'h000000, wd};
			@(posedge sys_clk);
			while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
			rd = avs_readdata;
			{avs_write, avs_read} <= 2'b00;
		end
	endtask
	task rchk(input [9:0] idx, input [7:0] mask, input [7:0] ex, input string nm);
		begin
			bus(1'b0, idx, 8'h00);
			`CHK(nm, {24'h000000, ex}, rd & {24'h000000, mask})
		end
	endtask
	task settle;
		@(negedge sys_clk);
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (i = 0; i < 5; i++) rchk(ridx[49-10*i -: 10], 8'hFF, 8'h00, "reset");
		bus(1'b1, `EP_IDX_E_SIZE_H, 8'hFA);
		rchk(`EP_IDX_E_SIZE_H, 8'hFF, 8'h02, "size_high");
		avs_byteenable <= 4'h0;
		bus(1'b1, `EP_IDX_E_SIZE_L, 8'h55);
		avs_byteenable <= 4'h1;
		rchk(`EP_IDX_E_SIZE_L, 8'hFF, 8'h00, "size_low");
		`CHK("size", 11'h200, slot_e_max_packet_bytes)
		for (i = 0; i < 4; i++) begin
			c = cfgs[31-8*i -: 8];
			bus(1'b1, `EP_IDX_E_CFG, c);
			rchk(`EP_IDX_E_CFG, 8'hFF, c & 8'hEF, "cfg");
			`CHK("cfg_bits", c[7:5], {e_direction_select, e_interrupt_mode, e_isochronous})
			`CHK("cfg_index", c[3:0], e_ep_index)
			`CHK("cfg_decode", {c[7] & c[6], !c[7] && !c[6]}, {e_always_toggle, e_ping_enable})
		end
		bus(1'b1, `EP_IDX_D_CTRL, 8'h08);
		settle;
		`CHK("toggle_one", 1'b1, d_toggle)
		bus(1'b1, `EP_IDX_D_CTRL, 8'h0C);
		settle;
		`CHK("toggle_both", 1'b0, d_toggle)
		bus(1'b1, `EP_IDX_D_CTRL, 8'h02);
		settle;
		`CHK("nak_idle", 2'b01, {d_resp_stall, d_resp_nak})
		bus(1'b1, `EP_IDX_D_CTRL, 8'h00);
		fork
			host.run(4'hC, 1'b0, 1'b1, 1'b0);
			begin
				@(posedge d_busy);
				bus(1'b1, `EP_IDX_D_CTRL, 8'h03);
				settle;
				`CHK("mid_txn", 3'b100, {d_busy, d_resp_stall, d_resp_nak})
			end
		join
		settle;
		`CHK("after_txn", 2'b10, {d_resp_stall, d_resp_nak})
		rchk(`EP_IDX_D_CTRL, 8'h03, 8'h03, "pending");
		for (i = 0; i < 8; i++) begin
			{c, ok_b, in_b, sh_b} = tcs[87-11*i -: 11];
			bus(1'b1, `EP_IDX_D_CTRL, c);
			settle;
			`CHK("zero_length", {c[6], c[6]}, {d_in_send_zero_length, d_in_send_ready})
			host.run(4'h2, ok_b, in_b, sh_b);
			settle;
			ek = ok_b && (c[7] || (!in_b && sh_b && !c[5]));
			es = c[6] && !(ok_b && in_b && sh_b);
			exp_tog = exp_tog ^ ok_b;
			rchk(`EP_IDX_D_CTRL, 8'hF3, {c[7], es, c[5], exp_tog, 2'b00, ek, 1'b0}, "ctrl");
			`CHK("resp_nak", ek, d_resp_nak)
		end
		@(posedge sys_clk) d_fifo_empty <= 1'b0;
		settle;
		`CHK("ready_short", 1'b0, d_in_send_ready)
		@(posedge sys_clk) d_fifo_below_max <= 1'b0;
		settle;
		`CHK("ready_full", 1'b1, d_in_send_ready)
		wrap_up;
	end
endmodule // tb_usb_device_endpoint_control
